// file: rtl/spr_pkg.sv
package spr_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [4:0] IDX_MAC_CTRL = 5'h10;
  localparam logic [4:0] IDX_MAC_STAT = 5'h11;
  localparam logic [4:0] IDX_MAC_ADV = 5'h12;
  localparam logic [4:0] IDX_MAC_LP = 5'h13;
  localparam logic [4:0] IDX_MAC_SER = 5'h14;
  localparam logic [4:0] IDX_TX_GOOD = 5'h15;
  localparam logic [4:0] IDX_TX_CRC = 5'h16;
  localparam logic [4:0] IDX_MEDIA_CTRL = 5'h17;
  localparam logic [4:0] IDX_MEDIA_ADV = 5'h19;
  localparam logic [4:0] IDX_EXT_FIRST = 5'h10;
  localparam logic [4:0] IDX_PAGE = 5'h1f;

  // page select values
  localparam logic [15:0] PAGE_EXT3 = 16'h0003;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;

  // reset values and writable masks
  localparam logic [15:0] MAC_CTRL_RST = 16'h0100;
  localparam logic [15:0] MAC_CTRL_WMASK = 16'hfff8;
  localparam logic [15:0] MEDIA_CTRL_RST = 16'h0000;
  localparam logic [15:0] MEDIA_CTRL_WMASK = 16'h2800;
  localparam logic [15:0] ADV_RST = 16'h0000;
  localparam logic [15:0] LP_RST = 16'h0000;

  // mac pcs control field positions
  localparam int MC_IF_DIS = 15;
  localparam int MC_IF_RESTART = 14;
  localparam int MC_PD = 13;
  localparam int MC_ANEG_RESTART = 12;
  localparam int MC_FORCE_ADV = 11;
  localparam int MC_PRE_LSB = 8;
  localparam int MC_ANEG_EN = 7;
  localparam int MC_RX_INV = 6;
  localparam int MC_TX_INV = 5;
  localparam int MC_FAST_LINK = 4;
  localparam int MC_UNIDIR = 3;

  // media pcs control field positions
  localparam int MD_PD = 13;
  localparam int MD_FORCE_ADV = 11;

  // counters
  localparam logic [13:0] GOOD_LAST = 14'h270f;
  localparam logic [13:0] GOOD_RST = 14'h0000;
  localparam logic [7:0] CRC_SAT = 8'hff;
  localparam logic [7:0] CRC_RST = 8'h00;

  // preamble handling
  localparam logic [3:0] NIB_PRE = 4'h5;
  typedef enum logic [2:0] {
    SPR_PRE_NONE = 3'b000,
    SPR_PRE_ONE = 3'b001,
    SPR_PRE_TWO = 3'b010
  } spr_pre_t;

endpackage

// file: rtl/spr_preamble.sv
`timescale 1ns/1ps
module spr_preamble
  import spr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // packet start
  input wire logic [2:0] mode,
  input wire logic pktSop,
  input wire logic [15:0] pktNibbles,
  // decision
  output logic [1:0] prefixCount,
  output logic prefixValid
);

  typedef struct packed {
    logic [1:0] cnt;
    logic vld;
  } spr_pre_state_t;

  spr_pre_state_t s_q, s_d;
  logic firstBad;
  logic nextBad;

  // nibble 0 is the first on the wire and sits in the low bits
  always_comb begin
    s_d = s_q;
    firstBad = !(pktNibbles[3:0] == NIB_PRE && pktNibbles[7:4] == NIB_PRE);
    nextBad = !(pktNibbles[11:8] == NIB_PRE && pktNibbles[15:12] == NIB_PRE);
    s_d.vld = pktSop;
    if (pktSop) begin
      case (spr_pre_t'(mode))
        SPR_PRE_NONE: s_d.cnt = 2'h0;
        SPR_PRE_ONE: s_d.cnt = {1'b0, firstBad};
        // second byte only follows a first one
        SPR_PRE_TWO: s_d.cnt = firstBad ? (nextBad ? 2'h2 : 2'h1) : 2'h0;
        default: s_d.cnt = 2'h0; // reserved codes act as no change
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prefixCount = s_q.cnt;
  assign prefixValid = s_q.vld;

endmodule

// file: rtl/spr_page3_regs.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// - page value three maps indices 16-30 here
// - indices 0-15 always go to standard space
// - page value zero returns 16-30 to standard
// - bit15 disables mac side while media down
// - bit14 restarts mac side on link change
// - bit13 enables mac parallel detect
// - bit7 enables aneg; bit12 restarts, self-clears
// - bit11 advertises word; word writable then
// - preamble field defaults 001; 000 no change
// - mode 010 may prefix two bytes
// - bits 6 and 5 invert serial polarity
// - bit4 selects fast link-fail as status
// - bit3 allows transmit without valid link
// - status 9:8 shows mac remote fault
// - status 7:4 show partner advertised abilities
// - status 12,11,3:0 show pcs state flags
// - partner word holds last received code
// - comma realignment flag latches until read
// - signal detect latches until read
// - good packet count modulo 10000, active
// - crc error count saturates at 255
// - media bits 13 and 11 control aneg
// - media advertised word writable when forced
module spr_page3_regs
  import spr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // forward port to the standard register space
  output logic stdCyc,
  output logic stdWe,
  output logic [4:0] stdIdx,
  output logic [1:0] stdSel,
  output logic [15:0] stdDatW,
  input wire logic [15:0] stdDatR,
  input wire logic stdAck,
  output logic pageExt3,
  // media side events
  input wire logic mediaLinkUp,
  input wire logic fastLinkUp,
  input wire logic mediaTxGood,
  input wire logic mediaTxCrcErr,
  // mac side pcs state
  input wire logic pcsAlignErr,
  input wire logic pcsLpRestart,
  input wire logic [1:0] pcsRemoteFault,
  input wire logic [3:0] pcsLpAbility,
  input wire logic pcsLpAnegCap,
  input wire logic pcsLinkUp,
  input wire logic pcsAnegDone,
  input wire logic pcsSigDet,
  input wire logic [15:0] pcsLpWord,
  input wire logic pcsLpWordValid,
  input wire logic pcsCommaRealign,
  input wire logic pcsSigDetEvent,
  // sgmii packet start
  input wire logic pktSop,
  input wire logic [15:0] pktNibbles,
  output logic [1:0] prefixCount,
  output logic prefixValid,
  // mac side controls
  output logic macIfDisable,
  output logic macIfRestart,
  output logic macParallelDetectEn,
  output logic macAnegEn,
  output logic macAnegRestart,
  output logic macForceAdv,
  output logic [15:0] macAdvWord,
  output logic macRxInvert,
  output logic macTxInvert,
  output logic macLinkStatus,
  output logic macTxEnable,
  // media side controls
  output logic mediaParallelDetectEn,
  output logic mediaForceAdv,
  output logic [15:0] mediaAdvWord
);

  typedef struct packed {
    logic [15:0] page;
    logic [15:0] macCtrl;
    logic [15:0] macAdv;
    logic [15:0] lpWord;
    logic comma;
    logic sigDet;
    logic [13:0] goodCnt;
    logic goodActive;
    logic [7:0] crcCnt;
    logic [15:0] mediaCtrl;
    logic [15:0] mediaAdv;
    logic ack;
    logic fwdDone;
    logic [15:0] rdat;
    logic linkPrev;
    logic ifRestart;
    logic anegRestart;
    logic ifDis;
    logic linkStat;
    logic txEn;
  } spr_state_t;

  localparam spr_state_t ST_RST = '{
    page: PAGE_MAIN,
    macCtrl: MAC_CTRL_RST,
    macAdv: ADV_RST,
    lpWord: LP_RST,
    comma: 1'b0,
    sigDet: 1'b0,
    goodCnt: GOOD_RST,
    goodActive: 1'b0,
    crcCnt: CRC_RST,
    mediaCtrl: MEDIA_CTRL_RST,
    mediaAdv: ADV_RST,
    ack: 1'b0,
    fwdDone: 1'b0,
    rdat: 16'h0000,
    linkPrev: 1'b0,
    ifRestart: 1'b0,
    anegRestart: 1'b0,
    ifDis: 1'b0,
    linkStat: 1'b0,
    txEn: 1'b0
  };

  spr_state_t s_q, s_d;

  logic req;
  logic [4:0] idx;
  logic isPage;
  logic isExt;
  logic isStd;
  logic localHit;
  logic wr;
  logic rd;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic [15:0] rdMux;
  logic [15:0] macStat;

  // keep old bits where the byte lane is not enabled
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // address decode; bit 7 of the address is outside the map
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    idx = wb_adr_i[6:2];
    isPage = !wb_adr_i[7] && idx == IDX_PAGE;
    isExt = !wb_adr_i[7] && s_q.page == PAGE_EXT3 && idx >= IDX_EXT_FIRST && !isPage;
    isStd = !wb_adr_i[7] && !isPage && !isExt;
    localHit = req & !isStd & !s_q.ack;
    wr = localHit & wb_we_i;
    rd = localHit & !wb_we_i;
    wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wdat = wb_dat_i[15:0];
  end

  // live pcs status word, reserved bits tied low
  assign macStat = {3'h0, pcsAlignErr, pcsLpRestart, 1'b0, pcsRemoteFault,
                    pcsLpAbility, pcsLpAnegCap, pcsLinkUp, pcsAnegDone, pcsSigDet};

  // read data mux; anything unmapped reads as zero
  always_comb begin
    rdMux = 16'h0000;
    if (isPage) begin
      rdMux = s_q.page;
    end else if (isExt) begin
      case (idx)
        IDX_MAC_CTRL: rdMux = s_q.macCtrl & MAC_CTRL_WMASK;
        IDX_MAC_STAT: rdMux = macStat;
        IDX_MAC_ADV: rdMux = s_q.macAdv;
        IDX_MAC_LP: rdMux = s_q.lpWord;
        IDX_MAC_SER: rdMux = {s_q.comma, s_q.sigDet, 14'h0000};
        IDX_TX_GOOD: rdMux = {s_q.goodActive, 1'b0, s_q.goodCnt};
        IDX_TX_CRC: rdMux = {8'h00, s_q.crcCnt};
        IDX_MEDIA_CTRL: rdMux = s_q.mediaCtrl & MEDIA_CTRL_WMASK;
        IDX_MEDIA_ADV: rdMux = s_q.mediaAdv;
        default: rdMux = 16'h0000;
      endcase
    end
  end

  // next state
  always_comb begin
    s_d = s_q;

    // bus handshake: ack lasts one cycle, then falls
    if (s_q.ack) begin
      s_d.ack = 1'b0;
      s_d.fwdDone = 1'b0;
    end else if (localHit) begin
      s_d.ack = 1'b1;
      s_d.rdat = rdMux;
    end else if (stdCyc && stdAck) begin
      // forwarded access: latch data so the output comes from a flop
      s_d.ack = 1'b1;
      s_d.fwdDone = 1'b1;
      s_d.rdat = stdDatR;
    end

    // restart bit pulses once and then clears itself
    s_d.anegRestart = s_q.macCtrl[MC_ANEG_RESTART];
    s_d.macCtrl[MC_ANEG_RESTART] = 1'b0;

    // clear on read first, so that a new event below wins
    if (rd && isExt && idx == IDX_MAC_SER) begin
      s_d.comma = 1'b0;
      s_d.sigDet = 1'b0;
    end
    if (pcsCommaRealign) begin
      s_d.comma = 1'b1;
    end
    if (pcsSigDetEvent) begin
      s_d.sigDet = 1'b1;
    end

    // register writes
    if (wr && isPage) begin
      s_d.page = merge(s_q.page, wdat, wmask);
    end
    if (wr && isExt) begin
      case (idx)
        IDX_MAC_CTRL: s_d.macCtrl = merge(s_q.macCtrl, wdat, wmask & MAC_CTRL_WMASK);
        IDX_MAC_ADV: begin
          if (s_q.macCtrl[MC_FORCE_ADV]) begin
            s_d.macAdv = merge(s_q.macAdv, wdat, wmask);
          end
        end
        IDX_MEDIA_CTRL: s_d.mediaCtrl = merge(s_q.mediaCtrl, wdat, wmask & MEDIA_CTRL_WMASK);
        IDX_MEDIA_ADV: begin
          if (s_q.mediaCtrl[MD_FORCE_ADV]) begin
            s_d.mediaAdv = merge(s_q.mediaAdv, wdat, wmask);
          end
        end
        default: s_d.page = s_q.page; // read-only or unmapped, writes dropped
      endcase
    end

    // partner code word capture
    if (pcsLpWordValid) begin
      s_d.lpWord = pcsLpWord;
    end

    // good packet counter wraps at the modulus
    if (mediaTxGood) begin
      s_d.goodActive = 1'b1;
      s_d.goodCnt = (s_q.goodCnt == GOOD_LAST) ? GOOD_RST : s_q.goodCnt + 14'h0001;
    end

    // crc error counter sticks at full scale
    if (mediaTxCrcErr && s_q.crcCnt != CRC_SAT) begin
      s_d.crcCnt = s_q.crcCnt + 8'h01;
    end

    // media link policies, registered so outputs come from flops
    s_d.linkPrev = mediaLinkUp;
    s_d.ifRestart = s_q.macCtrl[MC_IF_RESTART] & (mediaLinkUp ^ s_q.linkPrev);
    s_d.ifDis = s_q.macCtrl[MC_IF_DIS] & !mediaLinkUp;
    s_d.linkStat = s_q.macCtrl[MC_FAST_LINK] ? fastLinkUp : mediaLinkUp;
    s_d.txEn = s_q.macCtrl[MC_UNIDIR] | mediaLinkUp;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // forward port; held until the standard space answers
  assign stdCyc = req & isStd & !s_q.ack & !s_q.fwdDone;
  assign stdWe = wb_we_i;
  assign stdIdx = idx;
  assign stdSel = wb_sel_i[1:0];
  assign stdDatW = wdat;

  // bus answer; upper half of the word is always zero
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {16'h0000, s_q.rdat};
  assign pageExt3 = s_q.page == PAGE_EXT3;

  // preamble decision lives in its own small block
  spr_preamble u_pre (
    .clk(clk),
    .sys_rst(sys_rst),
    .mode(s_q.macCtrl[MC_PRE_LSB +: 3]),
    .pktSop(pktSop),
    .pktNibbles(pktNibbles),
    .prefixCount(prefixCount),
    .prefixValid(prefixValid)
  );

  // mac side control outputs
  assign macIfDisable = s_q.ifDis;
  assign macIfRestart = s_q.ifRestart;
  assign macParallelDetectEn = s_q.macCtrl[MC_PD];
  assign macAnegEn = s_q.macCtrl[MC_ANEG_EN];
  assign macAnegRestart = s_q.anegRestart;
  assign macForceAdv = s_q.macCtrl[MC_FORCE_ADV];
  assign macAdvWord = s_q.macAdv;
  assign macRxInvert = s_q.macCtrl[MC_RX_INV];
  assign macTxInvert = s_q.macCtrl[MC_TX_INV];
  assign macLinkStatus = s_q.linkStat;
  assign macTxEnable = s_q.txEn;

  // media side control outputs
  assign mediaParallelDetectEn = s_q.mediaCtrl[MD_PD];
  assign mediaForceAdv = s_q.mediaCtrl[MD_FORCE_ADV];
  assign mediaAdvWord = s_q.mediaAdv;

endmodule

// file: tb/spr_page3_regs_assertions.sv
`timescale 1ns/1ps
module spr_page3_regs_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // forward port and page
  input wire logic stdCyc,
  input wire logic stdAck,
  input wire logic pageExt3,
  // link and packet side
  input wire logic mediaLinkUp,
  input wire logic fastLinkUp,
  input wire logic pktSop,
  input wire logic [15:0] pktNibbles,
  input wire logic [1:0] prefixCount,
  input wire logic prefixValid,
  input wire logic macLinkStatus,
  input wire logic macTxEnable,
  input wire logic macIfDisable,
  input wire logic macAnegRestart
);
  logic req;
  logic pageWr;
  // new request only; ack high marks the answer cycle
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign pageWr = req && wb_we_i && wb_adr_i[7:2] == 6'h1f && wb_sel_i[1:0] == 2'h3;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence sopAnswer;
    pktSop ##1 prefixValid;
  endsequence

  chk_page_select: assert property (pageWr && wb_dat_i[15:0] == 16'h0003 |=> pageExt3)
    else $error("page three not selected");
  chk_page_main: assert property (pageWr && wb_dat_i[15:0] == 16'h0000 |=> !pageExt3)
    else $error("page not returned");
  chk_low_fwd: assert property (req && wb_adr_i[7:6] == 2'h0 |-> stdCyc)
    else $error("low index not forwarded");
  chk_ext_local: assert property (req && pageExt3 && wb_adr_i[7:6] == 2'h1 && wb_adr_i[5:2] != 4'hf |-> !stdCyc ##1 ackPulse)
    else $error("page three access not local");
  chk_fwd_answer: assert property (stdCyc && stdAck |=> ackPulse)
    else $error("forwarded answer missing");
  chk_prefix_time: assert property (pktSop |-> sopAnswer)
    else $error("prefix decision late");
  chk_prefix_none: assert property (pktSop && pktNibbles[7:0] == 8'h55 |=> prefixCount == 2'h0)
    else $error("prefix added to clean start");
  chk_link_normal: assert property (mediaLinkUp == fastLinkUp |=> macLinkStatus == $past(mediaLinkUp))
    else $error("link status wrong");
  chk_tx_link: assert property (mediaLinkUp |=> macTxEnable)
    else $error("transmit blocked with link");
  chk_dis_link: assert property (mediaLinkUp |=> !macIfDisable)
    else $error("interface disabled with link");
  chk_restart_once: assert property (macAnegRestart |=> !macAnegRestart)
    else $error("restart pulse too long");
endmodule

bind spr_page3_regs spr_page3_regs_assertions spr_page3_regs_assertions_i (.*);

// file: tb/spr_std_model.sv
`timescale 1ns/1ps
module spr_std_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // forward port
  input wire logic stdCyc,
  input wire logic stdWe,
  input wire logic [4:0] stdIdx,
  input wire logic [1:0] stdSel,
  input wire logic [15:0] stdDatW,
  output logic [15:0] stdDatR,
  output logic stdAck
);
  logic [15:0] memQ [32];
  logic [2:0] waitQ;
  logic slowQ;
  // answers alternate prompt and slow; data churns outside the ack cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      stdAck <= 1'b0;
      waitQ <= 3'h0;
      slowQ <= 1'b0;
      stdDatR <= 16'h0;
    end else begin
      stdDatR <= ~stdDatR;
      stdAck <= 1'b0;
      if (stdAck) begin
        waitQ <= 3'h0;
        slowQ <= ~slowQ;
        if (stdWe && stdSel[0]) memQ[stdIdx][7:0] <= stdDatW[7:0];
        if (stdWe && stdSel[1]) memQ[stdIdx][15:8] <= stdDatW[15:8];
      end else if (stdCyc) begin
        if (waitQ == (slowQ ? 3'h4 : 3'h0)) begin
          stdAck <= 1'b1;
          stdDatR <= memQ[stdIdx];
        end else begin
          waitQ <= waitQ + 3'h1;
        end
      end
    end
  end
endmodule

// file: tb/spr_page3_regs_test.sv
`timescale 1ns/1ps
module spr_page3_regs_test
  import spr_pkg::*;
;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stdCyc, stdWe, stdAck, pageExt3;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, pcsLpAbility;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [4:0] stdIdx;
  logic [1:0] stdSel, pcsRemoteFault, prefixCount;
  logic [15:0] stdDatW, stdDatR, pcsLpWord, pktNibbles, macAdvWord, mediaAdvWord;
  logic mediaLinkUp, fastLinkUp, mediaTxGood, mediaTxCrcErr, pcsAlignErr, pcsLpRestart, pcsLpAnegCap;
  logic pcsLinkUp, pcsAnegDone, pcsSigDet, pcsLpWordValid, pcsCommaRealign, pcsSigDetEvent, pktSop, prefixValid;
  logic macIfDisable, macIfRestart, macParallelDetectEn, macAnegEn, macAnegRestart, macForceAdv;
  logic macRxInvert, macTxInvert, macLinkStatus, macTxEnable, mediaParallelDetectEn, mediaForceAdv;
  logic [15:0] pats [4] = '{16'h0000, 16'h5500, 16'h0055, 16'h5555};
  int err_count, compares, cycles;

  spr_page3_regs spr_page3_regs_i (.*);
  spr_std_model spr_std_model_i (.*);

  always #20 clk = ~clk;
  // run limit well above the longest counter test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sig(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // one classic cycle; request held until ack is seen at an edge
  // no local wait limit: a slave that never answers is caught by the run limit
  task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] dat);
    bus(1'b1, {1'b0, idx, 2'h0}, dat);
  endtask

  task automatic rdc(input logic [4:0] idx, input logic [15:0] exp);
    bus(1'b0, {1'b0, idx, 2'h0}, 16'h0);
    chk(rd, {16'h0, exp});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [1:0] preExp(input logic [2:0] m, input logic [15:0] n);
    logic one;
    one = n[7:0] != 8'h55;
    if (m == 3'h1) return {1'b0, one};
    if (m == 3'h2) return {1'b0, one} + {1'b0, one && n[15:8] != 8'h55};
    return 2'h0;
  endfunction

  initial begin
    logic seen;
    {wb_cyc_i, wb_stb_i, wb_we_i, mediaLinkUp, fastLinkUp, mediaTxGood, mediaTxCrcErr, pktSop} = '0;
    {pcsAlignErr, pcsLpRestart, pcsLpAnegCap, pcsLinkUp, pcsAnegDone, pcsSigDet} = '0;
    {pcsLpWordValid, pcsCommaRealign, pcsSigDetEvent} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, pcsRemoteFault, pcsLpAbility, pcsLpWord, pktNibbles} = '0;
    {err_count, compares, cycles} = '0;
    clk = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // paging and forwarding, unmapped space
    wr(5'h10, 16'h1357);
    wr(IDX_PAGE, PAGE_EXT3);
    rdc(IDX_MAC_CTRL, 16'h0100);
    rdc(IDX_MAC_ADV, 16'h0000);
    wr(5'h03, 16'h2468);
    rdc(5'h03, 16'h2468);
    bus(1'b0, 8'hc0, 16'h0);
    chk(rd, 32'h0);
    $display("test paging done");
    // control bits; reserved and self-clearing bits read back low
    wr(IDX_MAC_CTRL, 16'hffff);
    // restart pulse stands in the cycle after the write lands
    sig(macAnegRestart, 1'b1);
    rdc(IDX_MAC_CTRL, 16'heff8);
    settle;
    sig(macAnegRestart, 1'b0);
    sig(macIfDisable, 1'b1);
    sig(macParallelDetectEn, 1'b1);
    sig(macAnegEn, 1'b1);
    sig(macRxInvert & macTxInvert, 1'b1);
    sig(macTxEnable, 1'b1);
    fastLinkUp <= 1'b1;
    settle;
    sig(macLinkStatus, 1'b1);
    seen = 1'b0;
    mediaLinkUp <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      seen |= macIfRestart;
    end
    sig(seen, 1'b1);
    sig(macIfDisable, 1'b0);
    wr(IDX_MAC_CTRL, 16'h0100);
    mediaLinkUp <= 1'b0;
    settle;
    sig(macTxEnable, 1'b0);
    sig(macLinkStatus, 1'b0);
    $display("test control done");
    // advertised words gated by force bits
    wr(IDX_MAC_ADV, 16'h1234);
    rdc(IDX_MAC_ADV, 16'h0000);
    wr(IDX_MAC_CTRL, 16'h0900);
    sig(macForceAdv, 1'b1);
    wr(IDX_MAC_ADV, 16'habcd);
    rdc(IDX_MAC_ADV, 16'habcd);
    chk({16'h0, macAdvWord}, 32'habcd);
    wr(IDX_MEDIA_ADV, 16'h1111);
    rdc(IDX_MEDIA_ADV, 16'h0000);
    wr(IDX_MEDIA_CTRL, 16'hffff);
    rdc(IDX_MEDIA_CTRL, 16'h2800);
    wr(IDX_MEDIA_ADV, 16'h4321);
    rdc(IDX_MEDIA_ADV, 16'h4321);
    chk({16'h0, mediaAdvWord}, 32'h4321);
    sig(mediaParallelDetectEn & mediaForceAdv, 1'b1);
    $display("test advertise done");
    // status, partner word and sticky flags
    {pcsAlignErr, pcsLpRestart, pcsRemoteFault, pcsLpAbility, pcsLpAnegCap, pcsLinkUp, pcsAnegDone, pcsSigDet} <= 12'heaa;
    {pcsLpWordValid, pcsCommaRealign, pcsSigDetEvent} <= 3'h7;
    pcsLpWord <= 16'h5a5a;
    @(posedge clk);
    {pcsLpWordValid, pcsCommaRealign, pcsSigDetEvent} <= 3'h0;
    pcsLpWord <= 16'h0f0f;
    settle;
    rdc(IDX_MAC_STAT, 16'h1aaa);
    rdc(IDX_MAC_LP, 16'h5a5a);
    rdc(IDX_MAC_SER, 16'hc000);
    rdc(IDX_MAC_SER, 16'h0000);
    $display("test status done");
    // counters: wrap at ten thousand, saturate at 255
    mediaTxGood <= 1'b1;
    mediaTxCrcErr <= 1'b1;
    repeat (3) @(posedge clk);
    mediaTxGood <= 1'b0;
    repeat (297) @(posedge clk);
    mediaTxCrcErr <= 1'b0;
    settle;
    rdc(IDX_TX_GOOD, 16'h8003);
    rdc(IDX_TX_CRC, 16'h00ff);
    mediaTxGood <= 1'b1;
    repeat (9997) @(posedge clk);
    mediaTxGood <= 1'b0;
    settle;
    rdc(IDX_TX_GOOD, 16'h8000);
    $display("test counters done");
    // every preamble mode against clean and dirty starts
    for (int m = 0; m < 4; m++) begin
      wr(IDX_MAC_CTRL, 16'(m) << 8);
      for (int p = 0; p < 4; p++) begin
        pktNibbles <= pats[p];
        pktSop <= 1'b1;
        @(posedge clk);
        pktSop <= 1'b0;
        @(posedge clk);
        sig(prefixValid, 1'b1);
        chk({30'h0, prefixCount}, {30'h0, preExp(3'(m), pats[p])});
      end
    end
    $display("test preamble done");
    wr(IDX_PAGE, PAGE_MAIN);
    rdc(5'h10, 16'h1357);
    sig(pageExt3, 1'b0);
    $display("test return done");
    complete_run;
  end
endmodule
